// File: logic/hbc_core.sv
// Hazard barrier control: decode, issue stall, fetch flush and cache sync
`timescale 1ns/100ps
`default_nettype none

module hbc_core
    import hbc_pkg::*;
(
    // Clock, reset, enable
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // Issue slot
    input wire logic i_issue_valid,
    input wire logic [31:0] i_issue_instr,
    input wire logic [31:0] i_issue_addr,
    // Configuration from control registers
    input wire logic i_jump_barrier_config_bit,
    // Pending older effects
    input wire logic i_ctrl_writes_pending,
    // Cache agent handshake
    input wire logic i_cache_sync_done,
    // Issue control and fetch control
    output logic o_issue_stall,
    output logic o_fetch_flush,
    output logic o_barrier_done,
    output hbc_kind_e o_barrier_kind,
    // Cache agent request
    output logic o_cache_sync_req,
    output logic [31:0] o_cache_sync_addr,
    output logic o_sync_timeout
);
`include "hbc_regs.svh"

    // ****************************************
    // Decode
    // ****************************************
    hbc_dec_s dec;

    hbc_decode u_decode (
        .i_instr(i_issue_instr),
        .i_jump_barrier_config_bit(i_jump_barrier_config_bit),
        .o_dec(dec)
    );

    typedef enum logic [1:0] {
        HBC_ST_IDLE,
        HBC_ST_DRAIN,
        HBC_ST_SYNC,
        HBC_ST_FLUSH
    } hbc_state_e;

    hbc_state_e state;
    hbc_need_s need;
    logic [$clog2(`HBC_SYNC_TIMEOUT_CYC + 1)-1:0] sync_cnt;
    logic start;

    // A barrier is taken on the cycle it reaches the issue slot
    assign start = i_ce && (state == HBC_ST_IDLE) && i_issue_valid
        && (dec.kind != HBC_NONE);

    // ****************************************
    // Barrier sequencer
    // ****************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state <= HBC_ST_IDLE;
            need <= '0;
            o_barrier_kind <= HBC_NONE;
        end else if (i_ce) begin
            unique case (state)
                HBC_ST_IDLE: begin
                    if (start) begin
                        state <= HBC_ST_DRAIN;
                        need <= dec.need;
                        o_barrier_kind <= dec.kind;
                    end
                end
                HBC_ST_DRAIN: begin
                    // Older control writes must land before anyone younger issues
                    if (!i_ctrl_writes_pending) begin
                        if (need.cache_sync) begin
                            state <= HBC_ST_SYNC;
                        end else begin
                            state <= HBC_ST_FLUSH;
                        end
                    end
                end
                HBC_ST_SYNC: begin
                    if (i_cache_sync_done || o_sync_timeout) begin
                        state <= HBC_ST_FLUSH;
                    end
                end
                HBC_ST_FLUSH: begin
                    state <= HBC_ST_IDLE;
                    o_barrier_kind <= HBC_NONE;
                end
            endcase
        end
    end

    // ****************************************
    // Issue stall and fetch flush
    // ****************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_issue_stall <= 1'b0;
            o_fetch_flush <= 1'b0;
            o_barrier_done <= 1'b0;
        end else if (i_ce) begin
            o_fetch_flush <= 1'b0;
            o_barrier_done <= 1'b0;
            if (start) begin
                o_issue_stall <= 1'b1;
            end else if (state == HBC_ST_FLUSH) begin
                o_issue_stall <= 1'b0;
                o_barrier_done <= 1'b1;
                // Fetch is decoupled, so prefetched words may hold stale state
                o_fetch_flush <= need.fetch_clear;
            end
        end
    end

    // ****************************************
    // Cache sync request
    // ****************************************
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_cache_sync_req <= 1'b0;
            o_cache_sync_addr <= 32'h00000000;
        end else if (i_ce) begin
            if (start && dec.need.cache_sync) begin
                o_cache_sync_addr <= i_issue_addr;
            end
            if (state == HBC_ST_DRAIN && !i_ctrl_writes_pending && need.cache_sync) begin
                o_cache_sync_req <= 1'b1;
            end else if (state == HBC_ST_SYNC && (i_cache_sync_done || o_sync_timeout)) begin
                o_cache_sync_req <= 1'b0;
            end
        end
    end

    // Watchdog so a dead cache agent cannot hang issue forever
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sync_cnt <= '0;
            o_sync_timeout <= 1'b0;
        end else if (i_ce) begin
            if (state == HBC_ST_SYNC && !o_sync_timeout && !i_cache_sync_done) begin
                sync_cnt <= sync_cnt + 1'b1;
                o_sync_timeout <= (sync_cnt == ($bits(sync_cnt))'(`HBC_SYNC_TIMEOUT_CYC - 1));
            end else begin
                sync_cnt <= '0;
                o_sync_timeout <= 1'b0;
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    property p_stall_on_barrier;
        @(posedge i_clk) disable iff (!i_nrst) start |=> o_issue_stall;
    endproperty
    a_stall_on_barrier: assert property (p_stall_on_barrier) else $error("no stall");

    property p_no_release_while_pending;
        @(posedge i_clk) disable iff (!i_nrst)
            (state == HBC_ST_DRAIN && i_ctrl_writes_pending && i_ce) |=> o_issue_stall;
    endproperty
    a_no_release_while_pending: assert property (p_no_release_while_pending)
        else $error("released early");

    // Kind drops to none on the done edge, so the barrier is read one sample back
    property p_exception_return_flush;
        @(posedge i_clk) disable iff (!i_nrst)
            (o_barrier_done && $past(o_barrier_kind) == HBC_EXC_RETURN) |-> o_fetch_flush;
    endproperty
    a_exception_return_flush: assert property (p_exception_return_flush) else $error("return without flush");

    // Issue stays held and the request stands until the agent answers or the watchdog fires
    property p_sync_before_done;
        @(posedge i_clk) disable iff (!i_nrst)
            (state == HBC_ST_SYNC && i_ce && !i_cache_sync_done && !o_sync_timeout)
            |=> (state == HBC_ST_SYNC && o_cache_sync_req && !o_barrier_done);
    endproperty
    a_sync_before_done: assert property (p_sync_before_done) else $error("sync skipped");

    property p_exec_decode;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_issue_instr == 32'h000000C0) |-> dec.kind == HBC_EXEC_BARRIER;
    endproperty
    a_exec_decode: assert property (p_exec_decode) else $error("barrier not decoded");

    property p_hint_decode;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_issue_instr[31:26] == 6'h00 && i_issue_instr[5:0] == 6'h08
            && i_issue_instr[10]) |-> dec.need.fetch_clear;
    endproperty
    a_hint_decode: assert property (p_hint_decode) else $error("hint ignored");

    property p_icache_sync_instr_decode;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_issue_instr[31:26] == 6'h01 && i_issue_instr[20:16] == 5'h1F)
            |-> dec.kind == HBC_ICACHE_SYNC;
    endproperty
    a_icache_sync_instr_decode: assert property (p_icache_sync_instr_decode) else $error("sync not decoded");

    property p_plain_jump;
        @(posedge i_clk) disable iff (!i_nrst)
            (i_issue_instr[31:26] == 6'h00 && i_issue_instr[5:1] == 5'h04
            && !i_issue_instr[10]) |-> (dec.kind == HBC_JUMP_BARRIER) == i_jump_barrier_config_bit;
    endproperty
    a_plain_jump: assert property (p_plain_jump) else $error("config bit ignored");

    c_exec: cover property (@(posedge i_clk) start && dec.kind == HBC_EXEC_BARRIER);
    c_sync: cover property (@(posedge i_clk) state == HBC_ST_SYNC && i_cache_sync_done);
    c_flush: cover property (@(posedge i_clk) o_fetch_flush);

endmodule : hbc_core
`default_nettype wire

// File: logic/hbc_decode.sv
// Barrier instruction decoder
`timescale 1ns/100ps
`default_nettype none

module hbc_decode
    import hbc_pkg::*;
(
    // Instruction word and configuration
    input wire logic [31:0] i_instr,
    input wire logic i_jump_barrier_config_bit,
    // Decoded result
    output var hbc_dec_s o_dec
);
`include "hbc_regs.svh"

    logic [5:0] op;
    logic [5:0] fn;
    logic is_nop_family;
    logic is_jump;

    assign op = i_instr[`HBC_OP_MSB:`HBC_OP_LSB];
    assign fn = i_instr[5:0];
    // Zero-register shift form: older cores run the barrier as a plain no-op
    assign is_nop_family = (op == `HBC_OP_SPECIAL) && (fn == `HBC_FN_SLL)
        && (i_instr[25:11] == 15'h0000);
    assign is_jump = (op == `HBC_OP_SPECIAL)
        && ((fn == `HBC_FN_JR) || (fn == `HBC_FN_JALR));

    always_comb begin
        o_dec = '0;
        o_dec.kind = HBC_NONE;
        if (is_nop_family && (i_instr[10:6] == `HBC_SA_EXEC_BARRIER)) begin
            o_dec.kind = HBC_EXEC_BARRIER;
            o_dec.need.exec_clear = 1'b1;
        end else if (is_jump && i_instr[`HBC_HINT_BARRIER_BIT]) begin
            o_dec.kind = HBC_JUMP_BARRIER;
            o_dec.need.exec_clear = 1'b1;
            o_dec.need.fetch_clear = 1'b1;
            o_dec.need.is_jump = 1'b1;
        end else if (is_jump && i_jump_barrier_config_bit) begin
            // Plain jumps only settle execution hazards under the config bit
            o_dec.kind = HBC_JUMP_BARRIER;
            o_dec.need.exec_clear = 1'b1;
            o_dec.need.is_jump = 1'b1;
        end else if (i_instr == 32'h42000018) begin
            o_dec.kind = HBC_EXC_RETURN;
            o_dec.need.exec_clear = 1'b1;
            o_dec.need.fetch_clear = 1'b1;
        end else if ((op == `HBC_OP_REGISTER_IMMEDIATE_OPCODE_CLASS)
            && (i_instr[20:16] == `HBC_RT_ICACHE_SYNC_INSTR)) begin
            o_dec.kind = HBC_ICACHE_SYNC;
            o_dec.need.cache_sync = 1'b1;
        end
    end

endmodule : hbc_decode
`default_nettype wire

// File: logic/hbc_pkg.sv
// Types for the hazard barrier control block
package hbc_pkg;

    // ****************************************
    // Decoded barrier class
    // ****************************************
    typedef enum logic [2:0] {
        HBC_NONE,
        HBC_EXEC_BARRIER,
        HBC_JUMP_BARRIER,
        HBC_EXC_RETURN,
        HBC_ICACHE_SYNC
    } hbc_kind_e;

    typedef struct packed {
        logic exec_clear;
        logic fetch_clear;
        logic cache_sync;
        logic is_jump;
    } hbc_need_s;

    typedef struct packed {
        hbc_kind_e kind;
        hbc_need_s need;
    } hbc_dec_s;

endpackage : hbc_pkg

// File: logic/hbc_regs.svh
// Constants for the hazard barrier control block
`ifndef HBC_REGS_SVH
`define HBC_REGS_SVH

// ****************************************
// Instruction encoding fields
// ****************************************
`define HBC_OP_MSB 31
`define HBC_OP_LSB 26
`define HBC_OP_SPECIAL 6'h00
`define HBC_OP_REGISTER_IMMEDIATE_OPCODE_CLASS 6'h01
`define HBC_FN_JR 6'h08
`define HBC_FN_JALR 6'h09
`define HBC_FN_SLL 6'h00
`define HBC_HINT_BARRIER_BIT 10
`define HBC_RT_ICACHE_SYNC_INSTR 5'h1F
`define HBC_SA_SUPERSCALAR_NO_OPERATION 5'h01
`define HBC_SA_EXEC_BARRIER 5'h03

// ****************************************
// Timing counts
// ****************************************
`define HBC_SYNC_TIMEOUT_NS 1000
`define HBC_CLK_PERIOD_NS 5
`define HBC_SYNC_TIMEOUT_CYC (`HBC_SYNC_TIMEOUT_NS / `HBC_CLK_PERIOD_NS)

`endif

// File: verification/testbench.sv
// Self-checking bench for the hazard barrier control block
`timescale 1ns/100ps
`default_nettype none
`include "hbc_regs.svh"

module testbench;
    import hbc_pkg::*;

    // ****************************************
    // Signals
    // ****************************************
    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic i_ce = 1'b1;
    logic i_issue_valid = 1'b0;
    logic [31:0] i_issue_instr = 32'h00000000;
    logic [31:0] i_issue_addr = 32'h00000000;
    logic i_jump_barrier_config_bit = 1'b0;
    logic i_ctrl_writes_pending = 1'b0;
    logic i_cache_sync_done = 1'b0;
    logic o_issue_stall, o_fetch_flush, o_barrier_done, o_cache_sync_req, o_sync_timeout;
    hbc_kind_e o_barrier_kind;
    logic [31:0] o_cache_sync_addr;
    int failures = 0;
    int total_checks = 0;
    int cycles = 0;

    hbc_core i_dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_issue_valid(i_issue_valid),
        .i_issue_instr(i_issue_instr), .i_issue_addr(i_issue_addr),
        .i_jump_barrier_config_bit(i_jump_barrier_config_bit),
        .i_ctrl_writes_pending(i_ctrl_writes_pending), .i_cache_sync_done(i_cache_sync_done),
        .o_issue_stall(o_issue_stall), .o_fetch_flush(o_fetch_flush),
        .o_barrier_done(o_barrier_done), .o_barrier_kind(o_barrier_kind),
        .o_cache_sync_req(o_cache_sync_req), .o_cache_sync_addr(o_cache_sync_addr),
        .o_sync_timeout(o_sync_timeout));

    // ****************************************
    // Clock and hang guard
    // ****************************************
    initial begin
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            final_report();
        end
    end

    // ****************************************
    // Helpers; every task starts and ends 1 ns after a rising edge
    // ****************************************
    task automatic chk(input bit ok, input string msg);
        total_checks++;
        if (!ok) begin
            $display("wrong value at %0t: %s", $time, msg);
            failures++;
        end
    endtask : chk

    task automatic step();
        @(posedge i_clk);
        #1;
    endtask : step

    task automatic issue(input logic [31:0] instr, input logic [31:0] addr);
        i_issue_valid = 1'b1;
        i_issue_instr = instr;
        i_issue_addr = addr;
        step();
        i_issue_valid = 1'b0;
    endtask : issue

    // Flush may only show together with done, so a stray early pulse is caught
    task automatic run_bar(input logic [31:0] instr, input hbc_kind_e k, input logic fl);
        int n;
        issue(instr, 32'h00000000);
        n = 1;
        chk(o_issue_stall === 1'b1 && o_barrier_kind === k, "stall or kind after take");
        while (o_barrier_done !== 1'b1 && n < 20) begin
            chk(o_fetch_flush === 1'b0 && o_issue_stall === 1'b1, "early flush or stall drop");
            step();
            n++;
        end
        chk(n == 3, "done latency");
        chk(o_fetch_flush === fl && o_issue_stall === 1'b0, "flush or stall at done");
    endtask : run_bar

    task automatic not_taken(input logic [31:0] instr);
        issue(instr, 32'h00000000);
        repeat (3) begin
            chk(o_issue_stall === 1'b0 && o_barrier_kind === HBC_NONE
                && o_fetch_flush === 1'b0, "non-barrier stalled");
            step();
        end
    endtask : not_taken

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_decode();
        run_bar(32'h000000C0, HBC_EXEC_BARRIER, 1'b0);
        run_bar(32'h03E00408, HBC_JUMP_BARRIER, 1'b1);
        run_bar(32'h03E0FC09, HBC_JUMP_BARRIER, 1'b1);
        run_bar(32'h42000018, HBC_EXC_RETURN, 1'b1);
        not_taken(32'h00000040);
        not_taken(32'h00000000);
        not_taken(32'h03E00008);
        i_jump_barrier_config_bit = 1'b1;
        run_bar(32'h03E00008, HBC_JUMP_BARRIER, 1'b0);
        i_jump_barrier_config_bit = 1'b0;
    endtask : t_decode

    // Older control writes and a frozen clock enable both hold the barrier open
    task automatic t_pending();
        int n;
        i_ctrl_writes_pending = 1'b1;
        issue(32'h000000C0, 32'h00000000);
        repeat (8) begin
            chk(o_barrier_done === 1'b0 && o_issue_stall === 1'b1, "done while pending");
            step();
        end
        // Writes land while the enable is low, so only the freeze holds the barrier
        i_ctrl_writes_pending = 1'b0;
        i_ce = 1'b0;
        repeat (4) begin
            step();
            chk(o_barrier_done === 1'b0 && o_issue_stall === 1'b1, "moved while frozen");
        end
        i_ce = 1'b1;
        n = 0;
        while (o_barrier_done !== 1'b1 && n < 6) begin
            step();
            n++;
        end
        chk(o_barrier_done === 1'b1 && n == 2, "no done after writes landed");
    endtask : t_pending

    task automatic t_sync(input bit answer, input logic [31:0] addr);
        int n;
        issue(32'h041F0010, addr);
        n = 0;
        while (o_cache_sync_req !== 1'b1 && n < 6) begin
            step();
            n++;
        end
        chk(o_cache_sync_req === 1'b1 && o_barrier_kind === HBC_ICACHE_SYNC, "no sync req");
        chk(o_cache_sync_addr === addr, "sync line address");
        n = 0;
        if (answer) begin
            repeat (5) step();
            chk(o_barrier_done === 1'b0 && o_issue_stall === 1'b1, "done before sync");
            i_cache_sync_done = 1'b1;
            step();
            i_cache_sync_done = 1'b0;
        end else begin
            while (o_sync_timeout !== 1'b1 && n < 260) begin
                step();
                n++;
            end
            chk(n == `HBC_SYNC_TIMEOUT_CYC, "timeout");
        end
        n = 0;
        while (o_barrier_done !== 1'b1 && n < 4) begin
            step();
            n++;
        end
        chk(o_barrier_done === 1'b1 && o_cache_sync_req === 1'b0, "sync end");
    endtask : t_sync

    // Reset in mid-barrier clears every output and the next barrier is taken cleanly
    task automatic t_reset();
        i_ctrl_writes_pending = 1'b1;
        issue(32'h041F0010, 32'h00001240);
        i_nrst = 1'b0;
        step();
        chk(o_issue_stall === 1'b0 && o_barrier_kind === HBC_NONE
            && o_cache_sync_addr === 32'h00000000, "outputs after reset");
        i_ctrl_writes_pending = 1'b0;
        i_nrst = 1'b1;
        run_bar(32'h000000C0, HBC_EXEC_BARRIER, 1'b0);
    endtask : t_reset

    task automatic final_report();
        if (failures == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : final_report

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        repeat (6) step();
        chk(o_issue_stall === 1'b0 && o_barrier_kind === HBC_NONE, "outputs in reset");
        i_nrst = 1'b1;
        t_decode();
        t_pending();
        t_sync(1'b1, 32'h0000ABC0);
        run_bar(32'h03E00408, HBC_JUMP_BARRIER, 1'b1);
        t_sync(1'b0, 32'h00012340);
        t_reset();
        final_report();
    end

endmodule : testbench

`default_nettype wire
